/* File: hw/hic_map.svh */
// Register offsets, field positions, reset values and timing counts of the interrupt block
`ifndef HIC_MAP_SVH
`define HIC_MAP_SVH

`define HIC_OFS_PENDING 8'h08
`define HIC_OFS_AVAIL 8'h0C
`define HIC_OFS_VERSION 8'h10
`define HIC_OFS_CTL 8'h14

`define HIC_VER_MAJOR 16'h0001
`define HIC_VER_MINOR 16'h0301

`define HIC_TV_MSB 31
`define HIC_TV_LSB 16
`define HIC_CC_MSB 15
`define HIC_CC_LSB 8
`define HIC_INT_MSB 7
`define HIC_INT_LSB 3
`define HIC_EN_BIT 0

`define HIC_TV_RESET 16'h0001
`define HIC_CC_RESET 8'h01
`define HIC_EN_RESET 1'h0
`define HIC_PENDING_RESET 32'h0000_0000

// Spare port slot that carries the coalesced interrupt
`define HIC_COALESCE_INDEX 5'h1F

// One timer unit and the clock period, both in ns
`define HIC_MS_NS 1000000
`define HIC_CLK_NS 100
`define HIC_MS_CYCLES (`HIC_MS_NS / `HIC_CLK_NS)

`endif

/* File: hw/hic_pkg.sv */
// Types and shared functions of the interrupt block
package hic_pkg;

  typedef struct packed {
    logic [15:0] timeout_ms;
    logic [7:0] completion_threshold;
    logic [4:0] coalesce_index;
    logic [1:0] reserved;
    logic enable;
  } hic_ctl_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } hic_req_s;

  function automatic logic [5:0] hic_popcount(input logic [31:0] v);
    logic [5:0] n;
    n = 6'h00;
    for (int i = 0; i < 32; i++) begin
      n = n + {5'h00, v[i]};
    end
    return n;
  endfunction

endpackage

/* File: hw/hic_coalesce_timer.sv */
// Millisecond down-timer of the completion coalescing engine
`timescale 1ns/1ns
`default_nettype none

module hic_coalesce_timer (
  input wire logic clk,
  input wire logic reset,
  input wire logic load,
  input wire logic [15:0] load_value,
  input wire logic run,
  input wire logic ms_tick,
  output logic expire
);

  logic [15:0] coalesce_down_timer;

  // A zero load is reserved; treat it like one so it still expires
  assign expire = run && ms_tick && (coalesce_down_timer <= 16'h0001);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      coalesce_down_timer <= 16'h0001;
    end else if (load) begin
      coalesce_down_timer <= load_value;
    end else if (run && ms_tick) begin
      coalesce_down_timer <= coalesce_down_timer - 16'h0001;
    end
  end

endmodule

`default_nettype wire

/* File: hw/hic_completion_counter.sv */
// Completion counter of the coalescing engine
`timescale 1ns/1ns
`default_nettype none

module hic_completion_counter (
  input wire logic clk,
  input wire logic reset,
  input wire logic clear,
  input wire logic [5:0] completions,
  input wire logic [7:0] threshold,
  output logic hit
);

  logic [8:0] completion_counter;
  logic [8:0] sum;

  assign sum = completion_counter + {3'h0, completions};
  // Several ports may finish together, so reaching or passing the threshold counts
  assign hit = (threshold != 8'h00) && (sum >= {1'h0, threshold});

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      completion_counter <= 9'h000;
    end else if (clear) begin
      completion_counter <= 9'h000;
    end else if (sum[8]) begin
      completion_counter <= 9'h0FF;
    end else begin
      completion_counter <= sum;
    end
  end

endmodule

`default_nettype wire

/* File: hw/hic_irq_top.sv */
// Global interrupt status, port availability, version and completion coalescing
`timescale 1ns/1ns
`default_nettype none
`include "hic_map.svh"

module hic_irq_top #(
  parameter int MS_CYCLES = `HIC_MS_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [31:0] ports_available_strap,
  input wire logic [4:0] supported_port_count,
  input wire logic [31:0] port_irq_req,
  input wire logic [31:0] cmd_complete,
  input wire logic [31:0] cmd_outstanding,
  input wire logic [31:0] coalesce_port_select,
  input wire logic global_irq_enable,
  output logic irq,
  output logic coalesce_event,
  output logic [4:0] coalesce_msi_vector
);

  hic_pkg::hic_req_s req;
  hic_pkg::hic_ctl_s ctl;
  logic [15:0] ctl_timeout;
  logic [7:0] ctl_threshold;
  logic ctl_enable;
  logic wr_ctl;
  logic wr_pending;
  logic timer_load;
  logic [15:0] timer_load_value;
  logic counter_clear;
  logic [5:0] completions_now;
  logic any_pending;
  logic [31:0] port_irq_pending;
  logic [31:0] ports_available_mask;
  logic avail_loaded;
  logic [15:0] active_timeout;
  logic [7:0] active_threshold;
  logic enable_prev;
  logic enable_rise;
  logic [31:0] ms_count;
  logic ms_tick;
  logic timer_expire;
  logic count_hit;
  logic coalesce_fire;
  logic coalesce_run;
  logic [31:0] pending_set;
  logic [31:0] pending_clear;
  logic [31:0] coalesce_bit;
  logic [31:0] next_rdata;
  logic [31:0] selected;

  assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

  // Register write decode, shared by every writable word
  function automatic logic write_hit(input hic_pkg::hic_req_s r, input logic [7:0] ofs);
    return r.wr && (r.addr == ofs);
  endfunction

  assign wr_ctl = write_hit(req, `HIC_OFS_CTL);
  assign wr_pending = write_hit(req, `HIC_OFS_PENDING);

  // Keep the lowest set bits up to the port limit, never the coalescing slot, never empty
  function automatic logic [31:0] limit_mask(input logic [31:0] strap, input logic [4:0] np);
    logic [31:0] m;
    logic [5:0] kept;
    m = 32'h0000_0000;
    kept = 6'h00;
    for (int i = 0; i < 32; i++) begin
      if (strap[i] && (i != int'(`HIC_COALESCE_INDEX)) && (kept <= {1'h0, np})) begin
        m[i] = 1'b1;
        kept = kept + 6'h01;
      end
    end
    if (m == 32'h0000_0000) begin
      m[0] = 1'b1;
    end
    return m;
  endfunction

  // Mask is captured once after reset release, since a strap may not feed an async reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ports_available_mask <= 32'h0000_0001;
    end else if (!avail_loaded) begin
      ports_available_mask <= limit_mask(ports_available_strap, supported_port_count);
    end
  end

  // Later strap changes are ignored: the mask is hardware-initialised, not live
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      avail_loaded <= 1'b0;
    end else begin
      avail_loaded <= 1'b1;
    end
  end

  // Coalescing control register; index and reserved bits are fixed
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctl_timeout <= `HIC_TV_RESET;
      ctl_threshold <= `HIC_CC_RESET;
      ctl_enable <= `HIC_EN_RESET;
    end else if (wr_ctl) begin
      ctl_timeout <= req.wdata[`HIC_TV_MSB:`HIC_TV_LSB];
      ctl_threshold <= req.wdata[`HIC_CC_MSB:`HIC_CC_LSB];
      ctl_enable <= req.wdata[`HIC_EN_BIT];
    end
  end
  assign ctl = '{
    timeout_ms: ctl_timeout,
    completion_threshold: ctl_threshold,
    coalesce_index: `HIC_COALESCE_INDEX,
    reserved: 2'h0,
    enable: ctl_enable
  };

  // Enable edge detector; both sides reset low so no false rise follows reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      enable_prev <= 1'b0;
    end else begin
      enable_prev <= ctl.enable;
    end
  end
  assign enable_rise = ctl.enable && !enable_prev;

  // The engine works from copies taken at enable rise, so timeout and threshold writes while enabled have no effect
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      active_timeout <= `HIC_TV_RESET;
      active_threshold <= `HIC_CC_RESET;
    end else if (enable_rise) begin
      active_timeout <= ctl.timeout_ms;
      active_threshold <= ctl.completion_threshold;
    end
  end

  // Millisecond prescaler from the core clock; exact count keeps well inside five percent
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ms_count <= 32'h0000_0000;
    end else if (ms_tick || enable_rise) begin
      ms_count <= 32'h0000_0000;
    end else begin
      ms_count <= ms_count + 32'h0000_0001;
    end
  end
  assign ms_tick = (ms_count == 32'(MS_CYCLES - 1));

  // Only available ports can take part, whatever the select mask holds
  assign selected = coalesce_port_select & ports_available_mask;
  // The first decrement after a busy start may come up to one millisecond early
  assign coalesce_run = enable_prev && ((cmd_outstanding & selected) != 32'h0000_0000);

  // Enable rise loads the fresh timeout directly, since the working copy lands one edge later
  assign timer_load = enable_rise || coalesce_fire;
  assign timer_load_value = enable_rise ? ctl.timeout_ms : active_timeout;

  hic_coalesce_timer u_timer (
    .clk(clk),
    .reset(reset),
    .load(timer_load),
    .load_value(timer_load_value),
    .run(coalesce_run),
    .ms_tick(ms_tick),
    .expire(timer_expire)
  );

  // Held at zero while disabled, so a stale count cannot fire on the next enable
  assign counter_clear = coalesce_fire || !enable_prev;
  assign completions_now = enable_prev ? hic_pkg::hic_popcount(cmd_complete & selected) : 6'h00;

  hic_completion_counter u_counter (
    .clk(clk),
    .reset(reset),
    .clear(counter_clear),
    .completions(completions_now),
    .threshold(active_threshold),
    .hit(count_hit)
  );

  // Both causes in one cycle merge into a single event and a single reload
  assign coalesce_fire = ctl.enable && enable_prev && (timer_expire || count_hit);

  // Pending word: port events only on available ports, plus the coalescing slot
  assign coalesce_bit = 32'h0000_0001 << ctl.coalesce_index;
  assign pending_set = (port_irq_req & ports_available_mask)
                       | (coalesce_fire ? coalesce_bit : 32'h0000_0000);
  // Writes to the pending word can only clear bits
  assign pending_clear = wr_pending ? req.wdata : 32'h0000_0000;

  // Per bit, a set in the clearing cycle wins so no event is lost
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      port_irq_pending <= `HIC_PENDING_RESET;
    end else begin
      for (int i = 0; i < 32; i++) begin
        if (pending_set[i]) begin
          port_irq_pending[i] <= 1'b1;
        end else if (pending_clear[i]) begin
          port_irq_pending[i] <= 1'b0;
        end
      end
    end
  end

  // Read mux; reserved and unmapped words read as zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (req.addr)
      `HIC_OFS_PENDING: next_rdata = port_irq_pending;
      `HIC_OFS_AVAIL: next_rdata = ports_available_mask;
      `HIC_OFS_VERSION: next_rdata = {`HIC_VER_MAJOR, `HIC_VER_MINOR};
      `HIC_OFS_CTL: next_rdata = ctl;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Read answer strobe, one cycle after the read edge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= req.rd;
    end
  end

  // Read data holds the last answer until the next read
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
    end else if (req.rd) begin
      reg_rdata <= next_rdata;
    end
  end

  assign any_pending = port_irq_pending != 32'h0000_0000;

  // Host interrupt is a level that follows the pending word one cycle late while global_irq_enable is set
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= global_irq_enable && any_pending;
    end
  end

  // Event pulse lasts one cycle; when gated the pending bit still records the interrupt
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      coalesce_event <= 1'b0;
    end else begin
      coalesce_event <= coalesce_fire && global_irq_enable;
    end
  end

  // Vector is fixed, but registered so that every output leaves a flip-flop
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      coalesce_msi_vector <= 5'h00;
    end else begin
      coalesce_msi_vector <= ctl.coalesce_index;
    end
  end

endmodule

`default_nettype wire

/* File: tb/hic_irq_checker.sv */
// Port-level assertions of the interrupt block
`timescale 1ns/1ns
`default_nettype none
module hic_irq_checker #(
  parameter int MS_CYCLES = 10
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic [31:0] ports_available_strap,
  input wire logic [4:0] supported_port_count,
  input wire logic [31:0] port_irq_req,
  input wire logic [31:0] cmd_complete,
  input wire logic [31:0] cmd_outstanding,
  input wire logic [31:0] coalesce_port_select,
  input wire logic global_irq_enable,
  input wire logic irq,
  input wire logic coalesce_event,
  input wire logic [4:0] coalesce_msi_vector
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  vector_fixed_a: assert property (!$past(reset) |-> coalesce_msi_vector == 5'h1F)
    else $error("vector is not the spare index");
  version_word_a: assert property (reg_rd && reg_addr == 8'h10 |=> reg_rdata == 32'h0001_0301)
    else $error("version word wrong");
  ctl_fixed_a: assert property (reg_rd && reg_addr == 8'h14 |=> reg_rdata[7:0] == 8'hF8 || reg_rdata[7:0] == 8'hF9)
    else $error("control fixed bits wrong");
  mask_count_a: assert property (reg_rd && reg_addr == 8'h0C |=> reg_rdata != 32'h0 && !reg_rdata[31]
    && $countones(reg_rdata) <= $past(supported_port_count) + 1)
    else $error("available mask out of range");
  read_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  unmapped_zero_a: assert property (reg_rd && reg_addr == 8'h04 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  event_irq_a: assert property (coalesce_event && global_irq_enable |=> irq)
    else $error("coalesced event without irq");
  req_irq_a: assert property (port_irq_req[0] && global_irq_enable ##1 global_irq_enable |=> irq)
    else $error("port request without irq");
  irq_gate_a: assert property (!global_irq_enable |=> !irq)
    else $error("irq while globally disabled");
  event_gate_a: assert property (coalesce_event |-> $past(global_irq_enable))
    else $error("event while globally disabled");
  cover property (coalesce_event);
  cover property (irq);
  cover property (reg_wr && reg_addr == 8'h08);
endmodule
`default_nettype wire

/* File: tb/hic_irq_top_test.sv */
// Self-checking bench of the interrupt block
`timescale 1ns/1ns
`default_nettype none
module hic_irq_top_test;
  logic clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, glob = 1'b0, rvalid, irq, ev;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] wdata = '0, req = '0, done = '0, busy = '0, rdata;
  logic [4:0] vec;
  logic [31:0] exp_q[$];
  int n_fail = 0, cmp_count = 0, ev_count = 0;
  always #50 clk = ~clk;
  hic_irq_top #(.MS_CYCLES(10)) i_hic_irq_top (.clk(clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid),
    .ports_available_strap(32'h0000_00FF), .supported_port_count(5'h03), .port_irq_req(req),
    .cmd_complete(done), .cmd_outstanding(busy), .coalesce_port_select(32'h0000_0003),
    .global_irq_enable(glob), .irq(irq), .coalesce_event(ev), .coalesce_msi_vector(vec));
  task check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("Mismatches %0d of %0d comparisons", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  task pulse(input logic [31:0] b);
    @(posedge clk);
    done <= b;
    @(posedge clk);
    done <= 32'h0;
  endtask
  // Bounded wait for the next coalesced event, returns cycles waited
  task wait_ev(input int lim, output int c);
    int s;
    s = ev_count;
    c = 0;
    while (ev_count == s) begin
      @(negedge clk);
      c++;
      if (c > lim) begin
        n_fail++;
        test_done();
      end
    end
  endtask
  always @(posedge clk) begin
    if (rvalid === 1'b1) check(rdata, exp_q.pop_front());
    if (ev === 1'b1) ev_count++;
  end
  initial begin
    int c;
    logic [31:0] r, m;
    void'($urandom(59));
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    rd(8'h10, 32'h0001_0301);
    rd(8'h0C, 32'h0000_000F);
    rd(8'h14, 32'h0001_01F8);
    rd(8'h04, 32'h0);
    wr(8'h0C, 32'h0);
    wr(8'h10, 32'h0);
    rd(8'h0C, 32'h0000_000F);
    rd(8'h10, 32'h0001_0301);
    glob <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      r = $urandom;
      m = $urandom;
      @(posedge clk);
      req <= r;
      @(posedge clk);
      req <= 32'h0;
      rd(8'h08, r & 32'hF);
      wr(8'h08, m);
      rd(8'h08, r & ~m & 32'hF);
      wr(8'h08, 32'hFFFF_FFFF);
    end
    wr(8'h14, 32'h0064_0201);
    repeat (2) @(posedge clk);
    pulse(32'h4);
    pulse(32'h1);
    pulse(32'h2);
    wait_ev(5, c);
    rd(8'h08, 32'h8000_0000);
    check({31'h0, irq}, 32'h1);
    check({27'h0, vec}, 32'h1F);
    wr(8'h08, 32'h8000_0000);
    pulse(32'h3);
    wait_ev(5, c);
    pulse(32'h1);
    repeat (4) @(posedge clk);
    check(ev_count, 2);
    pulse(32'h1);
    wait_ev(5, c);
    // Engine off: completions must be ignored; fields change only while disabled
    wr(8'h14, 32'h0064_0200);
    wr(8'h14, 32'h0002_0000);
    repeat (2) pulse(32'h3);
    wr(8'h14, 32'h0002_0001);
    repeat (3) pulse(32'h3);
    busy <= 32'h4;
    repeat (40) @(posedge clk);
    check(ev_count, 3);
    busy <= 32'h2;
    wait_ev(40, c);
    wait_ev(40, c);
    check(c >= 19 && c <= 21, 1);
    glob <= 1'b0;
    req <= 32'h1;
    repeat (3) @(posedge clk);
    check(irq, 0);
    test_done();
  end
endmodule
bind hic_irq_top hic_irq_checker #(.MS_CYCLES(MS_CYCLES)) i_hic_irq_checker (.clk(clk), .reset(reset),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .ports_available_strap(ports_available_strap),
  .supported_port_count(supported_port_count), .port_irq_req(port_irq_req), .cmd_complete(cmd_complete),
  .cmd_outstanding(cmd_outstanding), .coalesce_port_select(coalesce_port_select),
  .global_irq_enable(global_irq_enable), .irq(irq), .coalesce_event(coalesce_event),
  .coalesce_msi_vector(coalesce_msi_vector));
`default_nettype wire
